// ==== core/szx_regs.svh ====
/*
 holds timing counts and field widths for the skip-if-zero execution block.
 assumes nothing; definitions only.
*/
`ifndef SZX_REGS_SVH
`define SZX_REGS_SVH
`define SZX_DATA_W      8
`define SZX_ADDR_W      8
`define SZX_BIT_W       3
`define SZX_SKIP_CYCLES 3
`define SZX_ZERO_BYTE   8'h00
`endif

// ==== core/szx_pkg.sv ====
/*
 types shared by the skip-if-zero execution block.
 assumes the constants header is on the include path.
*/
`include "szx_regs.svh"
package szx_pkg;
	typedef enum logic [1:0] {
		SZX_OP_NONE,
		SZX_OP_REWRITE_SKIP_IF_ZERO,
		SZX_OP_LOAD_SKIP_IF_ZERO,
		SZX_OP_BIT_SKIP_IF_CLEAR
	} szx_op_e;
	typedef enum logic [1:0] {
		SZX_ST_IDLE,
		SZX_ST_READ,
		SZX_ST_DUMMY
	} szx_state_e;
	typedef struct packed {
		logic                       valid;
		szx_op_e                    op;
		logic [`SZX_ADDR_W-1:0]     addr;
		logic [`SZX_BIT_W-1:0]      bit_sel;
	} szx_req_s;
	typedef struct packed {
		logic                       we;
		logic [`SZX_ADDR_W-1:0]     addr;
		logic [`SZX_DATA_W-1:0]     wdata;
	} szx_mem_s;
	typedef struct packed {
		szx_state_e                 st;
		szx_req_s                   req;
		logic                       busy;
		logic                       squash;
		logic                       done;
		logic                       flag_we;
		logic                       acc_we;
		logic [`SZX_DATA_W-1:0]     acc_data;
		logic                       rd;
		szx_mem_s                   mem;
	} szx_state_s;
endpackage

// ==== core/szx_skip_exec.sv ====
/*
 execution of the conditional skip instructions: rewrite, load into the working
 register, and single-bit test; a taken skip squashes the fetched next instruction.
 assumes data memory returns read data in the same cycle that o_mem_rd is high and that the
 pipeline holds off a new request while o_busy is high.
*/
// Function
// - the rewrite variant reads the addressed byte and writes the same value back.
// - the rewrite variant skips the next instruction when the byte is zero.
// - a taken skip inserts a dummy cycle, making the instruction three cycles long.
// - the load variant copies the byte to the working register and skips if it is zero.
// - the bit variant skips the next instruction when the selected bit is zero.
// - a nonzero test continues normally with no dummy cycle.
// - none of these instructions change any status flag.
`timescale 1ns/1ps
`include "szx_regs.svh"
module szx_skip_exec (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_reset_n,
	input  wire szx_pkg::szx_req_s      i_req,
	input  wire logic [`SZX_DATA_W-1:0] i_mem_rdata,
	output logic                        o_busy,
	output logic                        o_mem_rd,
	output szx_pkg::szx_mem_s           o_mem,
	output logic                        o_acc_we,
	output logic [`SZX_DATA_W-1:0]      o_acc_data,
	output logic                        o_squash,
	output logic                        o_done,
	output logic                        o_flag_we
);
	szx_pkg::szx_state_s st_ff;
	szx_pkg::szx_state_s nxt_st;

	default clocking core_cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);

	function automatic logic is_rewrite(input szx_pkg::szx_op_e op);
		is_rewrite = (op == szx_pkg::SZX_OP_REWRITE_SKIP_IF_ZERO);
	endfunction

	function automatic logic is_load(input szx_pkg::szx_op_e op);
		is_load = (op == szx_pkg::SZX_OP_LOAD_SKIP_IF_ZERO);
	endfunction

	function automatic logic is_bit(input szx_pkg::szx_op_e op);
		is_bit = (op == szx_pkg::SZX_OP_BIT_SKIP_IF_CLEAR);
	endfunction

	function automatic logic test_zero(input szx_pkg::szx_op_e op,
		input logic [`SZX_DATA_W-1:0] d, input logic [`SZX_BIT_W-1:0] b);
		if (is_bit(op))
			test_zero = ~d[b];
		else
			test_zero = (d == `SZX_ZERO_BYTE);
	endfunction

	always_comb begin
		nxt_st           = st_ff;
		nxt_st.rd        = 1'b0;
		nxt_st.mem.we    = 1'b0;
		nxt_st.acc_we    = 1'b0;
		nxt_st.squash    = 1'b0;
		nxt_st.done      = 1'b0;
		nxt_st.flag_we   = 1'b0;
		unique case (st_ff.st)
			szx_pkg::SZX_ST_IDLE: begin
				if (i_req.valid && i_req.op != szx_pkg::SZX_OP_NONE) begin
					nxt_st.req      = i_req;
					nxt_st.rd       = 1'b1;
					nxt_st.mem.addr = i_req.addr;
					nxt_st.busy     = 1'b1;
					nxt_st.st       = szx_pkg::SZX_ST_READ;
				end
			end
			szx_pkg::SZX_ST_READ: begin
				if (is_rewrite(st_ff.req.op)) begin
					nxt_st.mem.we    = 1'b1;
					nxt_st.mem.wdata = i_mem_rdata;
				end
				if (is_load(st_ff.req.op)) begin
					nxt_st.acc_we   = 1'b1;
					nxt_st.acc_data = i_mem_rdata;
				end
				if (test_zero(st_ff.req.op, i_mem_rdata, st_ff.req.bit_sel)) begin
					nxt_st.squash = 1'b1;
					nxt_st.st     = szx_pkg::SZX_ST_DUMMY;
				end else begin
					nxt_st.done = 1'b1;
					nxt_st.busy = 1'b0;
					nxt_st.st   = szx_pkg::SZX_ST_IDLE;
				end
			end
			szx_pkg::SZX_ST_DUMMY: begin
				nxt_st.done = 1'b1;
				nxt_st.busy = 1'b0;
				nxt_st.st   = szx_pkg::SZX_ST_IDLE;
			end
			default: nxt_st.st = szx_pkg::SZX_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign o_busy     = st_ff.busy;
	assign o_mem_rd   = st_ff.rd;
	assign o_mem      = st_ff.mem;
	assign o_acc_we   = st_ff.acc_we;
	assign o_acc_data = st_ff.acc_data;
	assign o_squash   = st_ff.squash;
	assign o_done     = st_ff.done;
	assign o_flag_we  = st_ff.flag_we;

	// read data is compared one edge after the block took it
	chk_rewrite_same_value: assert property (
		o_mem.we
		|-> (is_rewrite(st_ff.req.op) && o_mem.wdata == $past(i_mem_rdata)))
		else $error("rewrite value differs from the byte read");

	chk_rewrite_zero_skip: assert property (
		(o_mem.we && o_mem.wdata == `SZX_ZERO_BYTE)
		|-> o_squash)
		else $error("zero byte did not skip");

	chk_skip_three_cycles: assert property (
		(o_mem_rd ##1 o_squash)
		|-> ##1 (o_done && !o_busy))
		else $error("taken skip not three cycles");

	chk_load_acc_value: assert property (
		o_acc_we
		|-> (o_acc_data == $past(i_mem_rdata)
			&& o_squash == ($past(i_mem_rdata) == `SZX_ZERO_BYTE)))
		else $error("working register load or skip wrong");

	chk_bit_clear_skip: assert property (
		(o_mem_rd && is_bit(st_ff.req.op)) ##1 1'b1
		|-> (o_squash == ~$past(i_mem_rdata[st_ff.req.bit_sel])))
		else $error("bit test skip wrong");

	chk_nonzero_no_dummy: assert property (
		(o_mem_rd ##1 !o_squash)
		|-> (o_done && !o_busy))
		else $error("nonzero test inserted a dummy cycle");

	chk_flags_untouched: assert property (
		(o_busy || o_done)
		|-> !o_flag_we)
		else $error("status flag written");

	chk_bubble_clean: assert property (
		o_squash
		|=> (!o_mem.we && !o_acc_we && !o_mem_rd && o_done))
		else $error("bubble had a side effect");

	chk_read_one_cycle: assert property (
		o_mem_rd
		|=> !o_mem_rd)
		else $error("read strobe longer than one cycle");

	chk_read_sets_busy: assert property (
		o_mem_rd
		|-> o_busy)
		else $error("read issued while not busy");

	chk_read_bounded: assert property (
		o_mem_rd
		|-> ##[1:2] o_done)
		else $error("instruction did not finish in time");

	chk_squash_after_read: assert property (
		o_squash
		|-> ($past(o_mem_rd) && o_busy))
		else $error("dummy cycle not right after the read");

	chk_squash_one_cycle: assert property (
		o_squash
		|=> !o_squash)
		else $error("dummy cycle longer than one cycle");

	chk_done_frees_core: assert property (
		o_done
		|-> !o_busy)
		else $error("busy still high at done");

	chk_write_after_read: assert property (
		o_mem.we
		|-> ($past(o_mem_rd) && $stable(o_mem.addr)))
		else $error("write back not to the location read");

	chk_write_one_pulse: assert property (
		o_mem.we
		|=> !o_mem.we)
		else $error("write back longer than one cycle");

	chk_rewrite_writes: assert property (
		(o_mem_rd && is_rewrite(st_ff.req.op))
		|=> (o_mem.we && !o_acc_we))
		else $error("rewrite did not write back");

	chk_load_no_write: assert property (
		(o_mem_rd && is_load(st_ff.req.op))
		|=> (o_acc_we && !o_mem.we))
		else $error("load did not reach the working register");

	chk_bit_no_write: assert property (
		(o_mem_rd && is_bit(st_ff.req.op))
		|=> (!o_acc_we && !o_mem.we))
		else $error("bit test wrote a result");

	chk_acc_after_read: assert property (
		o_acc_we
		|-> $past(o_mem_rd))
		else $error("working register load without a read");

	chk_acc_data_held: assert property (
		!o_acc_we
		|-> $stable(o_acc_data))
		else $error("working register value moved without a load");

	chk_wdata_held: assert property (
		!o_mem.we
		|-> $stable(o_mem.wdata))
		else $error("write data moved without a write");

	cov_rewrite_skip: cover property (o_mem.we && o_squash);
	cov_rewrite_pass: cover property (o_mem.we && o_done);
	cov_load_noskip: cover property (o_acc_we && !o_squash);
	cov_load_skip: cover property (o_acc_we && o_squash);
	cov_bit_skip: cover property (o_squash && is_bit(st_ff.req.op));
endmodule

// ==== verification/szx_skip_exec_tb_top.sv ====
/*
 bench for the skip-if-zero execution block.
 assumes the package and constants header compile first.
*/
`timescale 1ns/1ps
`include "szx_regs.svh"
module szx_skip_exec_tb_top;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	szx_pkg::szx_req_s      req = '0;
	logic [`SZX_DATA_W-1:0] rdata = 8'h00;
	logic                   busy, mem_rd, acc_we, squash, done, flag_we;
	szx_pkg::szx_mem_s      mem;
	logic [`SZX_DATA_W-1:0] acc_data;
	int                     mismatches = 0;
	int                     checked = 0;
	int                     cycles = 0;
	wire  [7:0]             flags = {mem_rd, mem.we, acc_we, squash, done, busy, flag_we, 1'b0};
	szx_skip_exec szx_skip_exec_i (.i_core_clk(clk), .i_reset_n(rst_n), .i_req(req),
		.i_mem_rdata(rdata), .o_busy(busy), .o_mem_rd(mem_rd), .o_mem(mem),
		.o_acc_we(acc_we), .o_acc_data(acc_data), .o_squash(squash), .o_done(done),
		.o_flag_we(flag_we));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one instruction; the read byte is driven only in the cycle the block samples it
	task automatic run(input szx_pkg::szx_op_e op, input logic [2:0] b, input logic [7:0] d,
		input logic skip);
		logic wr;
		logic ld;
		wr = (op == szx_pkg::SZX_OP_REWRITE_SKIP_IF_ZERO);
		ld = (op == szx_pkg::SZX_OP_LOAD_SKIP_IF_ZERO);
		req = '{valid: 1'b1, op: op, addr: d ^ 8'h5a, bit_sel: b};
		@(posedge clk);
		#1;
		req.valid = 1'b0;
		rdata = d;
		chk("read", 8'h84, flags);
		chk("addr", d ^ 8'h5a, mem.addr);
		@(posedge clk);
		#1;
		rdata = ~d;
		chk("exec", {1'b0, wr, ld, skip, ~skip, skip, 2'b00}, flags);
		if (wr) begin
			chk("wdata", d, mem.wdata);
		end
		if (ld) begin
			chk("acc", d, acc_data);
		end
		if (skip) begin
			@(posedge clk);
			#1;
			chk("dummy", 8'h08, flags);
		end
	endtask
	task automatic t_rewrite();
		run(szx_pkg::SZX_OP_REWRITE_SKIP_IF_ZERO, 3'h0, 8'h00, 1'b1);
		run(szx_pkg::SZX_OP_REWRITE_SKIP_IF_ZERO, 3'h0, 8'h80, 1'b0);
	endtask
	task automatic t_load();
		run(szx_pkg::SZX_OP_LOAD_SKIP_IF_ZERO, 3'h0, 8'h00, 1'b1);
		run(szx_pkg::SZX_OP_LOAD_SKIP_IF_ZERO, 3'h0, 8'h01, 1'b0);
	endtask
	task automatic t_bit();
		for (int i = 0; i < 8; i++) begin
			run(szx_pkg::SZX_OP_BIT_SKIP_IF_CLEAR, 3'(i), ~(8'h01 << i), 1'b1);
			run(szx_pkg::SZX_OP_BIT_SKIP_IF_CLEAR, 3'(i), 8'h01 << i, 1'b0);
		end
	endtask
	// a request with no skip operation must leave the block idle
	task automatic t_none();
		req = '{valid: 1'b1, op: szx_pkg::SZX_OP_NONE, addr: 8'h3c, bit_sel: 3'h0};
		@(posedge clk);
		#1;
		req.valid = 1'b0;
		chk("none", 8'h00, flags);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1;
		chk("reset", 8'h00, flags);
		rst_n = 1'b1;
		t_rewrite();
		t_load();
		t_bit();
		t_none();
		wrap_up();
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 400) begin
			mismatches++;
			wrap_up();
		end
	end
endmodule
